// File: hw/afo_defines.vh
/*
  Register offsets, field positions, reset values and sizes of the
  sample buffer, knock report and attitude configuration block.
  Assumes it is included by bare name from design files only.
*/
`ifndef AFO_DEFINES_VH
`define AFO_DEFINES_VH

`define AFO_OFF_X_LOW 6'h32
`define AFO_OFF_X_HIGH 6'h33
`define AFO_OFF_Y_LOW 6'h34
`define AFO_OFF_Y_HIGH 6'h35
`define AFO_OFF_Z_LOW 6'h36
`define AFO_OFF_Z_HIGH 6'h37
`define AFO_OFF_BUF_CTRL 6'h38
`define AFO_OFF_BUF_STATE 6'h39
`define AFO_OFF_KNOCK 6'h3a
`define AFO_OFF_ATT_CONF 6'h3b

`define AFO_CTRL_MODE_HI 7
`define AFO_CTRL_MODE_LO 6
`define AFO_CTRL_TRIG_SEL 5
`define AFO_CTRL_CNT_HI 4
`define AFO_CTRL_CNT_LO 0
`define AFO_CTRL_RESET 8'h00

`define AFO_MODE_BYPASS 2'h0
`define AFO_MODE_FILL 2'h1
`define AFO_MODE_CIRC 2'h2
`define AFO_MODE_TRIG 2'h3

`define AFO_STATE_TRIG_BIT 7

`define AFO_ATT_EN_BIT 7
`define AFO_ATT_DZ_HI 6
`define AFO_ATT_DZ_LO 4
`define AFO_ATT_DIM_BIT 3
`define AFO_ATT_DIV_HI 2
`define AFO_ATT_DIV_LO 0
`define AFO_ATT_RESET 8'h00

`define AFO_SRC_DREADY 7
`define AFO_SRC_WMARK 1
`define AFO_SRC_OVR 0

`define AFO_DEPTH 32
`define AFO_ORIENT2_DEFAULT 2'h0
`define AFO_ORIENT3_DEFAULT 3'h0

`define AFO_CMD_READ_BIT 7
`define AFO_CMD_MULTI_BIT 6

`endif

// File: hw/afo_mem.v
/*
  Sample store: one write port, one read port with registered data.
  Assumes the user never reads and writes the same entry in one cycle.
*/
`timescale 1ns/1ns
`default_nettype none

module afo_mem #(
  parameter WIDTH = 48,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  input wire rd_en,
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data_q
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data_q <= mem[rd_addr];
    end
  end

endmodule // afo_mem

`default_nettype wire

// File: hw/afo_regs.v
/*
  Axis output bytes, 32-entry sample buffer with four policies, buffer
  status, knock report and attitude interrupt configuration, reached
  over a 4-wire serial register port (clock idles high, sampled on rise).
  Assumes samples, knock events and attitude codes arrive as one-cycle
  pulses on clk; the serial pins are asynchronous and are synchronised.
*/
`timescale 1ns/1ns
`default_nettype none

`include "afo_defines.vh"

module afo_regs #(
  parameter DEPTH = `AFO_DEPTH,
  parameter AW = 5
) (
  input wire clk,
  input wire rst,
  input wire spi_cs_n,
  input wire spi_sclk,
  input wire spi_sdi,
  output reg spi_sdo_q,
  output wire spi_sdo_oe,
  input wire sample_valid,
  input wire [15:0] sample_x,
  input wire [15:0] sample_y,
  input wire [15:0] sample_z,
  input wire [7:0] int_enable,
  input wire [7:0] int_map,
  input wire [4:0] other_src,
  input wire int_source_read,
  input wire sample_rate_register_write,
  input wire measure,
  input wire knock_event,
  input wire [2:0] knock_axes_enable,
  input wire [2:0] knock_sign_in,
  input wire [2:0] knock_first_in,
  input wire attitude_sample,
  input wire attitude2_valid,
  input wire [1:0] attitude2_code,
  input wire attitude3_valid,
  input wire [2:0] attitude3_code,
  output wire [2:0] dead_zone_code,
  output wire [2:0] divisor_code,
  output wire [7:0] attitude_status,
  output wire [7:0] int_source,
  output reg irq_pin_one,
  output reg irq_pin_two
);

  localparam SW = 48;
  localparam [6:0] DEPTH_C = DEPTH;
  localparam [2:0] ST_CMD = 3'b001;
  localparam [2:0] ST_RD = 3'b010;
  localparam [2:0] ST_WR = 3'b100;

  // Serial pins: two flops before use, third stage for edges
  reg [2:0] sclk_s_q;
  reg [1:0] cs_s_q;
  reg [1:0] sdi_s_q;
  reg cs_d_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_s_q <= 3'h7;
      cs_s_q <= 2'h3;
      sdi_s_q <= 2'h0;
      cs_d_q <= 1'b1;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], spi_sclk};
      cs_s_q <= {cs_s_q[0], spi_cs_n};
      sdi_s_q <= {sdi_s_q[0], spi_sdi};
      cs_d_q <= cs_s_q[1];
    end
  end
  wire cs_act = ~cs_s_q[1];
  wire sclk_rise = sclk_s_q[1] & ~sclk_s_q[2] & cs_act;
  wire sclk_fall = ~sclk_s_q[1] & sclk_s_q[2] & cs_act;
  wire cs_end = cs_s_q[1] & ~cs_d_q;

  reg [2:0] st_q;
  reg [2:0] bit_q;
  reg [7:0] rx_q;
  reg [7:0] tx_q;
  reg [5:0] addr_q;
  reg multi_q;
  reg axis_read_q;
  reg [7:0] ctrl_q;
  reg [7:0] att_q;
  reg [2:0] ksign_q;
  reg [2:0] kinv_q;
  reg trig_flag_q;
  reg [SW-1:0] out_q;
  reg out_valid_q;
  reg [6:0] cnt_q;
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg rd_pend_q;
  reg ovr_q;
  reg att_flag_q;
  reg [2:0] st2_q;
  reg [3:0] st3_q;
  reg pin_sel_d_q;

  wire [1:0] mode = ctrl_q[`AFO_CTRL_MODE_HI:`AFO_CTRL_MODE_LO];
  wire [4:0] level = ctrl_q[`AFO_CTRL_CNT_HI:`AFO_CTRL_CNT_LO];
  wire [SW-1:0] mem_rdata;
  wire [5:0] entries = cnt_q[5:0] + {5'h00, out_valid_q};
  wire byte_done = sclk_rise & (bit_q == 3'h7);
  wire [7:0] rx_byte = {rx_q[6:0], sdi_s_q[1]};

  function [7:0] reg_read;
    input [5:0] a;
    begin
      case (a)
        `AFO_OFF_X_LOW: reg_read = out_q[7:0];
        `AFO_OFF_X_HIGH: reg_read = out_q[15:8];
        `AFO_OFF_Y_LOW: reg_read = out_q[23:16];
        `AFO_OFF_Y_HIGH: reg_read = out_q[31:24];
        `AFO_OFF_Z_LOW: reg_read = out_q[39:32];
        `AFO_OFF_Z_HIGH: reg_read = out_q[47:40];
        `AFO_OFF_BUF_CTRL: reg_read = ctrl_q;
        `AFO_OFF_BUF_STATE: reg_read = {trig_flag_q, 1'b0, entries[5:0]};
        `AFO_OFF_KNOCK: reg_read = {1'b0, ksign_q, 1'b0, kinv_q};
        `AFO_OFF_ATT_CONF: reg_read = att_q;
        default: reg_read = 8'h00;
      endcase
    end
  endfunction

  wire [7:0] rd_byte = reg_read(addr_q);
  wire is_axis = (addr_q >= `AFO_OFF_X_LOW) && (addr_q <= `AFO_OFF_Z_HIGH);
  wire wr_strobe = (st_q == ST_WR) & byte_done;
  wire ctrl_wr = wr_strobe & (addr_q == `AFO_OFF_BUF_CTRL);

  // Serial transaction engine
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_CMD;
      bit_q <= 3'h0;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      addr_q <= 6'h00;
      multi_q <= 1'b0;
      axis_read_q <= 1'b0;
      spi_sdo_q <= 1'b0;
      ctrl_q <= `AFO_CTRL_RESET;
      att_q <= `AFO_ATT_RESET;
    end else if (!cs_act) begin
      st_q <= ST_CMD;
      bit_q <= 3'h0;
      axis_read_q <= 1'b0;
    end else begin
      if (sclk_rise) begin
        rx_q <= rx_byte;
        bit_q <= bit_q + 3'h1;
      end
      if (byte_done) begin
        case (st_q)
          ST_CMD: begin
            addr_q <= rx_byte[5:0];
            multi_q <= rx_byte[`AFO_CMD_MULTI_BIT];
            st_q <= rx_byte[`AFO_CMD_READ_BIT] ? ST_RD : ST_WR;
          end
          ST_RD: begin
            addr_q <= multi_q ? addr_q + 6'h01 : addr_q;
          end
          ST_WR: begin
            if (addr_q == `AFO_OFF_BUF_CTRL) begin
              ctrl_q <= rx_byte;
            end
            if (addr_q == `AFO_OFF_ATT_CONF) begin
              att_q <= rx_byte;
            end
            addr_q <= multi_q ? addr_q + 6'h01 : addr_q;
          end
          default: st_q <= ST_CMD;
        endcase
      end
      // Output byte loads on the falling edge that starts it
      if (sclk_fall && st_q == ST_RD) begin
        if (bit_q == 3'h0) begin
          tx_q <= rd_byte;
          spi_sdo_q <= rd_byte[7];
          if (is_axis) begin
            axis_read_q <= 1'b1;
          end
        end else begin
          tx_q <= {tx_q[6:0], 1'b0};
          spi_sdo_q <= tx_q[6];
        end
      end
    end
  end
  assign spi_sdo_oe = cs_act & (st_q == ST_RD);

  // One level leaves when the burst that touched the axis bytes ends
  wire pop = cs_end & axis_read_q;

  // Buffer datapath
  // No refill while a sample lands: a drop would free the entry being read
  wire rd_issue = ~out_valid_q & (cnt_q != 7'h00) & ~rd_pend_q & ~cs_act & ~sample_valid;
  wire [6:0] cnt_eff = cnt_q - {6'h00, rd_pend_q};
  wire is_full = (cnt_eff == DEPTH_C);
  reg push;
  reg drop;
  reg lost;
  always @* begin
    push = 1'b0;
    drop = 1'b0;
    lost = 1'b0;
    if (sample_valid) begin
      case (mode)
        `AFO_MODE_BYPASS: lost = out_valid_q;
        `AFO_MODE_FILL: begin
          push = ~is_full;
          lost = is_full;
        end
        `AFO_MODE_CIRC: begin
          push = 1'b1;
          drop = is_full;
          lost = is_full;
        end
        `AFO_MODE_TRIG: begin
          if (trig_flag_q) begin
            push = ~is_full;
            lost = is_full;
          end else begin
            push = 1'b1;
            drop = (cnt_eff != 7'h00) & (cnt_eff >= {2'h0, level});
          end
        end
        default: push = 1'b0;
      endcase
    end
  end
  wire [6:0] cnt_next = cnt_q + {6'h00, push} - {6'h00, rd_pend_q} - {6'h00, drop};
  wire [AW-1:0] rp_next = rp_q + {{(AW-1){1'b0}}, rd_pend_q} + {{(AW-1){1'b0}}, drop};

  afo_mem #(
    .WIDTH(SW),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .clk(clk),
    .wr_en(push),
    .wr_addr(wp_q),
    .wr_data({sample_z, sample_y, sample_x}),
    .rd_en(rd_issue),
    .rd_addr(rp_q),
    .rd_data_q(mem_rdata)
  );

  wire trig_pin = ctrl_q[`AFO_CTRL_TRIG_SEL] ? irq_pin_two : irq_pin_one;
  wire trig_hit = (mode == `AFO_MODE_TRIG) & trig_pin & ~pin_sel_d_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 7'h00;
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      rd_pend_q <= 1'b0;
      out_q <= {SW{1'b0}};
      out_valid_q <= 1'b0;
      trig_flag_q <= 1'b0;
      ovr_q <= 1'b0;
      pin_sel_d_q <= 1'b0;
    end else begin
      pin_sel_d_q <= trig_pin;
      if (mode == `AFO_MODE_BYPASS) begin
        cnt_q <= 7'h00;
        wp_q <= {AW{1'b0}};
        rp_q <= {AW{1'b0}};
        rd_pend_q <= 1'b0;
        // Holding the stage during a burst keeps the bytes coherent
        if (sample_valid && !cs_act) begin
          out_q <= {sample_z, sample_y, sample_x};
          out_valid_q <= 1'b1;
        end else if (pop) begin
          out_valid_q <= 1'b0;
        end
      end else begin
        cnt_q <= cnt_next;
        rp_q <= rp_next;
        wp_q <= wp_q + {{(AW-1){1'b0}}, push};
        rd_pend_q <= rd_issue;
        if (rd_pend_q) begin
          out_q <= mem_rdata;
          out_valid_q <= 1'b1;
        end else if (pop) begin
          out_valid_q <= 1'b0;
        end
      end
      // Trigger in the same cycle as a control write is kept
      if (trig_hit) begin
        trig_flag_q <= 1'b1;
      end else if (ctrl_wr) begin
        trig_flag_q <= 1'b0;
      end
      if (lost) begin
        ovr_q <= 1'b1;
      end else if (pop) begin
        ovr_q <= 1'b0;
      end
    end
  end

  // Watermark is a level, so it clears as reads drain the buffer below a nonzero level; a level of 0 holds it set
  wire wmark = (level == 5'h00) |
    ((mode != `AFO_MODE_BYPASS) & (entries >= {1'b0, level}));

  // Knock report, one slice per axis (x is the top bit)
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_knock
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          ksign_q[gi] <= 1'b0;
          kinv_q[gi] <= 1'b0;
        end else if (knock_event) begin
          if (knock_axes_enable[gi]) begin
            ksign_q[gi] <= knock_sign_in[gi];
          end
          kinv_q[gi] <= knock_axes_enable[gi] & knock_first_in[gi];
        end
      end
    end
  endgenerate

  // Attitude status and interrupt
  wire att_en = att_q[`AFO_ATT_EN_BIT] & int_enable[`AFO_SRC_OVR];
  wire att_reset = sample_rate_register_write | ~measure;
  wire chg2 = attitude2_valid & (attitude2_code != st2_q[1:0]);
  wire chg3 = attitude3_valid & (attitude3_code != st3_q[2:0]);
  wire att_fire = attitude_sample & (att_q[`AFO_ATT_DIM_BIT] ? chg3 : chg2);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st2_q <= {1'b0, `AFO_ORIENT2_DEFAULT};
      st3_q <= {1'b0, `AFO_ORIENT3_DEFAULT};
      att_flag_q <= 1'b0;
    end else if (att_reset) begin
      st2_q <= {1'b0, `AFO_ORIENT2_DEFAULT};
      st3_q <= {1'b0, `AFO_ORIENT3_DEFAULT};
      att_flag_q <= 1'b0;
    end else begin
      if (attitude_sample) begin
        // Dead zone: an invalid code leaves the last orientation in place
        st2_q <= attitude2_valid ? {1'b1, attitude2_code} : {1'b0, st2_q[1:0]};
        st3_q <= attitude3_valid ? {1'b1, attitude3_code} : {1'b0, st3_q[2:0]};
      end
      if (!att_en) begin
        att_flag_q <= 1'b0;
      end else if (att_fire) begin
        att_flag_q <= 1'b1;
      end else if (int_source_read) begin
        att_flag_q <= 1'b0;
      end
    end
  end
  assign attitude_status = {1'b0, st2_q[2], st2_q[1:0], st3_q[3], st3_q[2:0]};
  assign dead_zone_code = att_q[`AFO_ATT_DZ_HI:`AFO_ATT_DZ_LO];
  assign divisor_code = att_q[`AFO_ATT_DIV_HI:`AFO_ATT_DIV_LO];

  assign int_source = {out_valid_q, other_src, wmark,
    att_q[`AFO_ATT_EN_BIT] ? att_flag_q : ovr_q};

  wire [7:0] active = int_source & int_enable;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_pin_one <= 1'b0;
      irq_pin_two <= 1'b0;
    end else begin
      irq_pin_one <= |(active & ~int_map);
      irq_pin_two <= |(active & int_map);
    end
  end

endmodule // afo_regs

`default_nettype wire

// File: tb/afo_host_model.sv
/*
  Serial host model: four-wire master, clock idles high, data out on fall.
  Assumes clk at 100 ns; one link clock period is eight clk cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module afo_host_model (
  input wire logic clk,
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_sdi,
  input wire logic spi_sdo_q,
  input wire logic spi_sdo_oe
);
  logic [7:0] wbuf [8];
  logic [7:0] rbuf [8];
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b1;
    spi_sdi = 1'b0;
  end
  task automatic half();
    repeat (4) @(posedge clk);
  endtask
  // Command byte first, then n data bytes; read bits taken on each rise
  task automatic xfer(input logic [7:0] cmd, input int n);
    logic [7:0] w;
    @(posedge clk);
    spi_cs_n <= 1'b0;
    for (int b = 0; b <= n; b++) begin
      w = (b == 0) ? cmd : wbuf[b-1];
      for (int i = 7; i >= 0; i--) begin
        half();
        spi_sclk <= 1'b0;
        spi_sdi <= w[i];
        half();
        spi_sclk <= 1'b1;
        if (b > 0)
          rbuf[b-1][i] = spi_sdo_q;
      end
    end
    half();
    spi_cs_n <= 1'b1;
    // Released line toggles so no stale bit can pass for data
    spi_sdi <= ~spi_sdi;
    repeat (8) @(posedge clk);
  endtask
endmodule // afo_host_model
`default_nettype wire

// File: tb/afo_regs_assertions.sv
/*
  Port-level checker for afo_regs: interrupt pins, attitude status, pops.
  Assumes int_enable is zero while reset is held.
*/
`timescale 1ns/1ns
`default_nettype none
module afo_regs_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic spi_cs_n,
  input wire logic spi_sdo_oe,
  input wire logic sample_valid,
  input wire logic [7:0] int_enable,
  input wire logic [7:0] int_map,
  input wire logic sample_rate_register_write,
  input wire logic measure,
  input wire logic attitude_sample,
  input wire logic attitude2_valid,
  input wire logic [1:0] attitude2_code,
  input wire logic attitude3_valid,
  input wire logic [2:0] attitude3_code,
  input wire logic [7:0] attitude_status,
  input wire logic [7:0] int_source,
  input wire logic irq_pin_one,
  input wire logic irq_pin_two
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic live1;
  logic live2;
  assign live1 = |(int_source & int_enable & ~int_map);
  assign live2 = |(int_source & int_enable & int_map);
  a_pin_one_or: assert property (irq_pin_one == $past(live1))
    else $error("pin one differs from its mapped sources");
  a_pin_two_or: assert property (irq_pin_two == $past(live2))
    else $error("pin two differs from its mapped sources");
  a_rate_reset: assert property (sample_rate_register_write |=> attitude_status == 8'h00)
    else $error("attitude status kept after rate write");
  a_standby_reset: assert property (!measure |=> attitude_status == 8'h00)
    else $error("attitude status kept in standby");
  a_att2_update: assert property (attitude_sample && attitude2_valid && measure &&
    !sample_rate_register_write |=> attitude_status[6:4] == {1'b1, $past(attitude2_code)})
    else $error("two-axis status not taken");
  a_att3_update: assert property (attitude_sample && attitude3_valid && measure &&
    !sample_rate_register_write |=> attitude_status[3:0] == {1'b1, $past(attitude3_code)})
    else $error("three-axis status not taken");
  a_ready_pop: assert property ($fell(int_source[7]) |-> spi_cs_n && $past(spi_cs_n, 2))
    else $error("ready dropped without a finished access");
  // Select is synchronised, so drive may trail the pin by a few cycles
  a_drive_in_frame: assert property (spi_sdo_oe |-> !spi_cs_n || !$past(spi_cs_n, 3))
    else $error("data out driven outside a frame");
  cover property (sample_valid ##[1:4] int_source[7]);
  cover property ($rose(irq_pin_two));
  cover property (attitude_sample && attitude3_valid);
endmodule // afo_regs_assertions
bind afo_regs afo_regs_assertions u_chk (.clk, .rst, .spi_cs_n, .spi_sdo_oe, .sample_valid,
  .int_enable, .int_map, .sample_rate_register_write, .measure, .attitude_sample,
  .attitude2_valid, .attitude2_code, .attitude3_valid, .attitude3_code, .attitude_status,
  .int_source, .irq_pin_one, .irq_pin_two);
`default_nettype wire

// File: tb/afo_regs_tb.sv
/*
  Self-checking bench for afo_regs through the serial host model.
  Assumes clk of 100 ns and the checker bound to the design.
*/
`timescale 1ns/1ns
`default_nettype none
module afo_regs_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic spi_cs_n, spi_sclk, spi_sdi, spi_sdo_q, spi_sdo_oe, irq_pin_one, irq_pin_two;
  logic sample_valid = 1'b0, int_source_read = 1'b0, knock_event = 1'b0, measure = 1'b1;
  logic sample_rate_register_write = 1'b0, attitude_sample = 1'b0;
  logic attitude2_valid = 1'b0, attitude3_valid = 1'b0;
  logic [1:0] attitude2_code = 2'h0;
  logic [2:0] attitude3_code = 3'h0, knock_axes_enable = 3'h0, knock_sign_in = 3'h0;
  logic [2:0] knock_first_in = 3'h0, dead_zone_code, divisor_code;
  logic [4:0] other_src = 5'h00;
  logic [7:0] int_enable = 8'h00, int_map = 8'h00, attitude_status, int_source;
  logic [15:0] sample_x = 16'h0000, sample_y = 16'h0000, sample_z = 16'h0000;
  int fail_count = 0;
  int cmp_count = 0;
  afo_host_model host (.clk, .spi_cs_n, .spi_sclk, .spi_sdi, .spi_sdo_q, .spi_sdo_oe);
  afo_regs dut (.clk, .rst, .spi_cs_n, .spi_sclk, .spi_sdi, .spi_sdo_q, .spi_sdo_oe,
    .sample_valid, .sample_x, .sample_y, .sample_z, .int_enable, .int_map, .other_src,
    .int_source_read, .sample_rate_register_write, .measure, .knock_event,
    .knock_axes_enable, .knock_sign_in, .knock_first_in, .attitude_sample,
    .attitude2_valid, .attitude2_code, .attitude3_valid, .attitude3_code,
    .dead_zone_code, .divisor_code, .attitude_status, .int_source, .irq_pin_one,
    .irq_pin_two);
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host.wbuf[0] = d;
    host.xfer({2'b00, a}, 1);
  endtask
  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    host.xfer({2'b10, a}, 1);
    chk(host.rbuf[0], e);
  endtask
  task automatic push(input logic [15:0] v);
    sample_x <= v;
    sample_y <= ~v;
    sample_z <= v ^ 16'h5a5a;
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    cyc(3);
  endtask
  // Whole sample in one burst, low byte first per axis
  task automatic rs(input logic [15:0] v);
    logic [47:0] e;
    e = {v ^ 16'h5a5a, ~v, v};
    host.xfer(8'hf2, 6);
    for (int i = 0; i < 6; i++)
      chk(host.rbuf[i], e[8*i+:8]);
  endtask
  task automatic att(input logic [6:0] s);
    {attitude2_valid, attitude2_code, attitude3_valid, attitude3_code} <= s;
    attitude_sample <= 1'b1;
    @(posedge clk);
    attitude_sample <= 1'b0;
    cyc(2);
  endtask
  task automatic knock(input logic [2:0] en, input logic [2:0] sg, input logic [2:0] fi);
    {knock_axes_enable, knock_sign_in, knock_first_in} <= {en, sg, fi};
    knock_event <= 1'b1;
    @(posedge clk);
    knock_event <= 1'b0;
  endtask
  initial begin
    #4000000;
    fail_count++;
    $display("watchdog expired");
    conclude();
  end
  initial begin
    cyc(12);
    rst <= 1'b0;
    cyc(4);
    rc(6'h38, 8'h00);
    rc(6'h3b, 8'h00);
    chk(int_source, 8'h02);
    wr(6'h39, 8'hff);
    rc(6'h39, 8'h00);
    rc(6'h10, 8'h00);
    $display("reset test done");
    wr(6'h38, 8'h05);
    push(16'h1234);
    chk(int_source & 8'h83, 8'h80);
    push(16'h8001);
    chk(int_source & 8'h01, 8'h01);
    rs(16'h8001);
    chk(int_source & 8'h81, 8'h00);
    $display("bypass test done");
    wr(6'h38, 8'h44);
    chk(int_source & 8'h02, 8'h00);
    for (int i = 0; i < 34; i++)
      push(16'(i));
    rc(6'h39, 8'h21);
    chk(int_source & 8'h03, 8'h03);
    rs(16'h0000);
    rs(16'h0001);
    rc(6'h39, 8'h1f);
    wr(6'h38, 8'h00);
    rs(16'h0002);
    rc(6'h39, 8'h00);
    $display("fill test done");
    wr(6'h38, 8'h80);
    for (int i = 0; i < 40; i++)
      push(16'(100 + i));
    rc(6'h39, 8'h21);
    rs(16'd100);
    rs(16'd108);
    wr(6'h38, 8'h00);
    rs(16'd109);
    $display("circular test done");
    int_enable <= 8'h50;
    int_map <= 8'h40;
    wr(6'h38, 8'he4);
    for (int i = 0; i < 10; i++)
      push(16'(200 + i));
    other_src <= 5'h04;
    cyc(4);
    other_src <= 5'h00;
    rc(6'h39, 8'h05);
    other_src <= 5'h10;
    cyc(4);
    other_src <= 5'h00;
    rc(6'h39, 8'h85);
    for (int i = 0; i < 40; i++)
      push(16'(210 + i));
    rc(6'h39, 8'ha1);
    rs(16'd200);
    rs(16'd206);
    wr(6'h38, 8'h00);
    rs(16'd207);
    rc(6'h39, 8'h00);
    $display("trigger test done");
    knock(3'b111, 3'b101, 3'b100);
    rc(6'h3a, 8'h54);
    knock(3'b011, 3'b010, 3'b011);
    rc(6'h3a, 8'h63);
    $display("knock test done");
    for (int c = 0; c < 8; c++) begin
      wr(6'h3b, {1'b0, 3'(c), 1'b0, 3'(7 - c)});
      chk({5'h00, dead_zone_code}, 8'(c));
      chk({5'h00, divisor_code}, 8'(7 - c));
    end
    rc(6'h3b, 8'h70);
    int_enable <= 8'h01;
    int_map <= 8'h01;
    wr(6'h3b, 8'h80);
    chk(int_source & 8'h01, 8'h00);
    att(7'h68);
    chk({int_source[0], irq_pin_two, 6'h00}, 8'hc0);
    int_source_read <= 1'b1;
    @(posedge clk);
    int_source_read <= 1'b0;
    cyc(2);
    chk(int_source & 8'h01, 8'h00);
    att(7'h29);
    chk(int_source & 8'h01, 8'h00);
    chk(attitude_status, 8'h29);
    att(7'h79);
    chk(int_source & 8'h01, 8'h01);
    int_enable <= 8'h00;
    cyc(2);
    chk(int_source & 8'h01, 8'h00);
    int_enable <= 8'h01;
    wr(6'h3b, 8'h88);
    att(7'h3c);
    chk(int_source & 8'h01, 8'h01);
    sample_rate_register_write <= 1'b1;
    @(posedge clk);
    sample_rate_register_write <= 1'b0;
    cyc(2);
    chk({attitude_status[6:0], int_source[0]}, 8'h00);
    att(7'h0e);
    chk(int_source & 8'h01, 8'h01);
    measure <= 1'b0;
    cyc(2);
    measure <= 1'b1;
    cyc(2);
    chk({attitude_status[6:0], int_source[0]}, 8'h00);
    $display("attitude test done");
    conclude();
  end
endmodule // afo_regs_tb
`default_nettype wire
